// file: design/wdr_pkg.sv
package wdr_pkg;
   // Register addresses on the CPU byte bus.
   localparam logic [31:0] WDR_KEY_ADDR = 32'hFFFFF6D1;
   localparam logic [31:0] WDR_MODE_ADDR = 32'hFFFFF6D0;
   // Key values.
   localparam logic [7:0] WDR_RESTART_KEY = 8'hAC;
   localparam logic [7:0] WDR_KEY_READ = 8'h9A;
   // Mode and interval register layout and reset value.
   localparam int WDR_ACT_HI_BIT = 6;
   localparam int WDR_ACT_LO_BIT = 5;
   localparam int WDR_SEL_MSB = 4;
   localparam logic [7:0] WDR_MODE_RESET = 8'h7A;
   localparam logic [4:0] WDR_SEL_STOP = 5'h1F;
   localparam logic [1:0] WDR_ACT_NMI = 2'h1;
   // Last counter value; a loop detection interval is this plus one count clock ticks.
   localparam logic [7:0] WDR_TERMINAL = 8'hFF;

   typedef logic [4:0] wdr_sel_t;
endpackage : wdr_pkg

// file: design/wdr_tick_if.sv
interface wdr_tick_if;
   import wdr_pkg::*;
   wdr_sel_t sel;
   logic clear;
   logic tick;
   modport ctrl (output sel, output clear, input tick);
   modport presc (input sel, input clear, output tick);
endinterface : wdr_tick_if

// file: design/wdr_prescaler.sv
module wdr_prescaler
   import wdr_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // Count clock selection and tick.
   wdr_tick_if.presc tk
);
   logic [31:0] div_q;
   logic [31:0] div_d;
   logic [31:0] mask;

   // The count clock period is two to the power of the selection plus one.
   always_comb begin
      mask = 32'((33'h1 << (6'(tk.sel) + 6'h1)) - 33'h1);
      // The tick is not gated by clear; the controller already ignores it while clearing.
      tk.tick = (div_q & mask) == mask;
      div_d = tk.clear ? 32'h0 : div_q + 32'h1;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         div_q <= 32'h0;
      end else begin
         div_q <= div_d;
      end
   end
endmodule : wdr_prescaler

// file: design/wdr_watchdog.sv
// How it works
// - Writing the restart key to the key register clears the counter and restarts counting at zero.
// - Writing any other value to the key register forces an overflow at once.
// - A single-bit write to the key register forces an overflow at once.
// - Reading the key register always returns the fixed read pattern.
// - After reset the watchdog counts on its own with overflow action set to system reset.
// - The mode and interval register takes one byte write after reset and ignores later ones.
// - The five-bit clock selection field picks the count clock and so the interval.
// - An expired interval raises a reset request or an NMI request as the mode bits select.
// - An overflow in power save with the upper mode bit set raises a reset request.
// - An overflow in power save in NMI mode gives a wake pulse instead of an NMI.
module wdr_watchdog
   import wdr_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // CPU byte bus.
   input wire logic [31:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic bit_access_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   // System side.
   input wire logic power_save_i,
   output logic watchdog_reset_request_o,
   output logic watchdog_nmi_request_o,
   output logic wake_o
);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
      return a == reg_addr;
   endfunction

   // The prescaler makes the count clock; a clear restarts its period.
   wdr_tick_if tk ();

   wdr_prescaler u_presc (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .tk(tk)
   );

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] mode_q;
   logic [7:0] mode_d;
   logic written_q;
   logic written_d;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] rdata_d;
   logic rst_req_d;
   logic nmi_d;
   logic wake_d;
   // Decoded strobes and overflow causes, all of the current cycle.
   logic key_wr;
   logic restart;
   logic bad_key;
   logic running;
   logic timeout;
   logic ovf;
   logic [1:0] act;

   always_comb begin
      act = mode_q[WDR_ACT_HI_BIT:WDR_ACT_LO_BIT];
      running = mode_q[WDR_SEL_MSB:0] != WDR_SEL_STOP;
      key_wr = wr_i && hit(addr_i, WDR_KEY_ADDR);
      restart = key_wr && !bit_access_i && (wdata_i == WDR_RESTART_KEY);
      bad_key = key_wr && (bit_access_i || (wdata_i != WDR_RESTART_KEY));
      // A restart wins over a timeout in the same cycle, so a late key still saves the system.
      timeout = running && tk.tick && (cnt_q == WDR_TERMINAL) && !restart;
      ovf = timeout || bad_key;
      tk.sel = mode_q[WDR_SEL_MSB:0];
      // Clearing the prescaler on a restart makes every interval start on a full period.
      // The tick does not depend on this clear, which keeps the timeout free of a loop.
      tk.clear = restart || ovf || !running;
      // Counter.
      cnt_d = cnt_q;
      if (restart || ovf || !running) begin
         cnt_d = 8'h00;
      end else if (tk.tick) begin
         cnt_d = cnt_q + 8'h01;
      end
      // One-shot mode register.
      // Bit accesses never land, so a stray bit write cannot use up the one write.
      mode_d = mode_q;
      written_d = written_q;
      if (wr_i && hit(addr_i, WDR_MODE_ADDR) && !bit_access_i && !written_q) begin
         mode_d = wdata_i;
         written_d = 1'b1;
      end
      // Read data.
      // The key register never gives back the value last written.
      rdata_d = 8'h00;
      if (rd_i && hit(addr_i, WDR_KEY_ADDR)) begin
         rdata_d = WDR_KEY_READ;
      end else if (rd_i && hit(addr_i, WDR_MODE_ADDR)) begin
         rdata_d = mode_q;
      end
      // Overflow action.
      // In power save an NMI cannot be served, so NMI mode wakes the device instead.
      rst_req_d = ovf && act[1];
      nmi_d = ovf && (act == WDR_ACT_NMI) && !power_save_i;
      wake_d = ovf && (act == WDR_ACT_NMI) && power_save_i;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_q <= WDR_MODE_RESET;
         written_q <= 1'b0;
         cnt_q <= 8'h00;
         rdata_o <= 8'h00;
         watchdog_reset_request_o <= 1'b0;
         watchdog_nmi_request_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         mode_q <= mode_d;
         written_q <= written_d;
         cnt_q <= cnt_d;
         rdata_o <= rdata_d;
         watchdog_reset_request_o <= rst_req_d;
         watchdog_nmi_request_o <= nmi_d;
         wake_o <= wake_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   AST_KEY_RESTART: assert property (
      restart && running |=> cnt_q == 8'h00 ##1 (cnt_q == 8'h00 || $past(tk.tick)))
      else $error("restart key did not clear the counter");
   AST_BAD_KEY: assert property (
      key_wr && !bit_access_i && wdata_i != WDR_RESTART_KEY && act[1]
      |=> watchdog_reset_request_o)
      else $error("wrong key did not force a reset request");
   AST_BIT_ACCESS: assert property (
      key_wr && bit_access_i && act == WDR_ACT_NMI && !power_save_i
      |=> watchdog_nmi_request_o)
      else $error("bit access to key did not force an overflow");
   AST_KEY_READ: assert property (
      rd_i && hit(addr_i, WDR_KEY_ADDR) |=> rdata_o == WDR_KEY_READ)
      else $error("key read did not return the fixed pattern");
   AST_AUTOSTART: assert property (
      $past(reset_i) |-> act[1] && running && !written_q)
      else $error("watchdog not started in reset mode after reset");
   AST_ONE_WRITE: assert property (
      written_q |=> $stable(mode_q) && written_q)
      else $error("mode register changed after its single write");
   AST_TICK_ONLY: assert property (
      cnt_q != 8'h00 && $changed(cnt_q) |-> $past(tk.tick) && cnt_q == $past(cnt_q) + 8'h01)
      else $error("counter advanced without a count clock tick");
   AST_TIMEOUT: assert property (
      timeout && act == WDR_ACT_NMI && !power_save_i
      |=> watchdog_nmi_request_o && !watchdog_reset_request_o ##1 !watchdog_nmi_request_o)
      else $error("timeout in NMI mode did not give one NMI pulse");
   AST_PS_RESET: assert property (
      ovf && power_save_i && act[1] |=> watchdog_reset_request_o && !wake_o)
      else $error("power save overflow in reset mode did not reset");
   AST_PS_WAKE: assert property (
      ovf && power_save_i && act == WDR_ACT_NMI |=> wake_o && !watchdog_nmi_request_o)
      else $error("power save overflow in NMI mode did not wake");
   AST_FORCED_SAME: assert property (
      bad_key |=> watchdog_reset_request_o == $past(act[1]))
      else $error("forced overflow took a different action");

   // Every request pulse has an overflow of the matching mode one cycle earlier.
   AST_RST_CAUSE: assert property (
      watchdog_reset_request_o |-> $past(ovf) && $past(act[1]))
      else $error("reset request without an overflow in reset mode");
   AST_NMI_CAUSE: assert property (
      watchdog_nmi_request_o
      |-> $past(ovf) && $past(act) == WDR_ACT_NMI && !$past(power_save_i))
      else $error("NMI request without an overflow in NMI mode");
   AST_WAKE_CAUSE: assert property (
      wake_o |-> $past(ovf) && $past(act) == WDR_ACT_NMI && $past(power_save_i))
      else $error("wake pulse without an overflow in power save");
   AST_RESET_MODE: assert property (
      timeout && act[1] |=> watchdog_reset_request_o && !watchdog_nmi_request_o)
      else $error("timeout in reset mode did not give a reset request");
   AST_QUIET_MODE: assert property (
      ovf && act == 2'h0 |=> !watchdog_reset_request_o && !watchdog_nmi_request_o && !wake_o)
      else $error("overflow with no action selected gave a request");
   AST_RESTART_QUIET: assert property (
      restart |=> !watchdog_reset_request_o && !watchdog_nmi_request_o && !wake_o)
      else $error("restart key write raised a request");
   AST_NO_BOTH: assert property (
      !(watchdog_reset_request_o && watchdog_nmi_request_o))
      else $error("reset and NMI requests raised together");

   // Counter, count clock and mode register.
   AST_TIMEOUT_CLEARS: assert property (
      timeout |=> cnt_q == 8'h00)
      else $error("counter did not restart after a timeout");
   AST_STOPPED: assert property (
      !running |=> cnt_q == 8'h00)
      else $error("counter moved with the stop selection");
   AST_TICK_SPACED: assert property (
      tk.tick |=> !tk.tick)
      else $error("count clock ticked in two cycles running");
   AST_MODE_LANDS: assert property (
      wr_i && hit(addr_i, WDR_MODE_ADDR) && !bit_access_i && !written_q
      |=> mode_q == $past(wdata_i) && written_q)
      else $error("first mode write did not land");
   AST_MODE_BIT_IGNORED: assert property (
      wr_i && hit(addr_i, WDR_MODE_ADDR) && bit_access_i |=> $stable(mode_q))
      else $error("bit access changed the mode register");
   AST_MODE_READ: assert property (
      rd_i && hit(addr_i, WDR_MODE_ADDR) |=> rdata_o == $past(mode_q))
      else $error("mode register read gave a wrong value");

   // Main scenarios; the bench reaches all but COV_RESTART (two restarts within 20 cycles), as its restarts lie about 400 cycles apart.
   COV_TIMEOUT: cover property (timeout ##1 watchdog_reset_request_o);
   COV_RESTART: cover property (restart ##[1:20] restart);
   COV_WAKE: cover property (wake_o);
   COV_MODE_WRITE: cover property (!written_q ##1 written_q);
   COV_BIT_ACCESS: cover property (key_wr && bit_access_i ##1 watchdog_nmi_request_o);
endmodule : wdr_watchdog

// file: sim/wdr_watchdog_tb.sv
module wdr_watchdog_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import wdr_pkg::*;
   logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, bit_access_i = 0, power_save_i = 0;
   logic [31:0] addr_i = 32'h0;
   logic [7:0] wdata_i = 8'h0, rdata_o;
   logic watchdog_reset_request_o, watchdog_nmi_request_o, wake_o;
   int err_total = 0, samples_checked = 0, n_rst = 0, n_nmi = 0, n_wake = 0, s_r, s_n, s_w;
   wdr_watchdog dut_u (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i),
      .rd_i(rd_i), .bit_access_i(bit_access_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .power_save_i(power_save_i), .watchdog_reset_request_o(watchdog_reset_request_o),
      .watchdog_nmi_request_o(watchdog_nmi_request_o), .wake_o(wake_o));
   always #5 clk_i = ~clk_i;
   // Each request output is a one-cycle pulse, so counting samples counts events.
   always @(posedge clk_i) begin
      n_rst += int'(watchdog_reset_request_o === 1'b1);
      n_nmi += int'(watchdog_nmi_request_o === 1'b1);
      n_wake += int'(wake_o === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [31:0] a, input logic w, input logic b, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_i = a;
      wr_i = w;
      rd_i = ~w;
      bit_access_i = b;
      wdata_i = d;
      @(posedge clk_i);
      #1;
      wr_i = 0;
      rd_i = 0;
      bit_access_i = 0;
      wdata_i = ~d;
   endtask
   task automatic bad(input logic [7:0] d, input logic b);
      acc(WDR_KEY_ADDR, 1'b1, b, d);
      @(posedge clk_i);
      #1;
   endtask
   task automatic snap();
      s_r = n_rst;
      s_n = n_nmi;
      s_w = n_wake;
   endtask
   task automatic dlt(input int r, input int n, input int w);
      chk(8'(n_rst - s_r), 8'(r));
      chk(8'(n_nmi - s_n), 8'(n));
      chk(8'(n_wake - s_w), 8'(w));
   endtask
   task automatic do_reset();
      reset_i = 1;
      repeat (10) @(posedge clk_i);
      #1;
      reset_i = 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_read();
      snap();
      acc(WDR_KEY_ADDR, 1'b0, 1'b0, 8'h00);
      chk(rdata_o, WDR_KEY_READ);
      acc(WDR_KEY_ADDR, 1'b1, 1'b0, WDR_RESTART_KEY);
      acc(WDR_KEY_ADDR, 1'b0, 1'b0, 8'h00);
      chk(rdata_o, WDR_KEY_READ);
      acc(32'hFFFFF6D2, 1'b0, 1'b0, 8'h00);
      chk(rdata_o, 8'h00);
      dlt(0, 0, 0);
      $display("test_read done");
   endtask
   task automatic test_bad_key();
      logic [7:0] vals [3] = '{8'h00, 8'h9A, 8'hAD};
      foreach (vals[i]) begin
         snap();
         bad(vals[i], 1'b0);
         dlt(1, 0, 0);
      end
      snap();
      bad(WDR_RESTART_KEY, 1'b1);
      dlt(1, 0, 0);
      $display("test_bad_key done");
   endtask
   task automatic test_nmi_mode();
      acc(WDR_MODE_ADDR, 1'b1, 1'b0, 8'h20);
      acc(WDR_MODE_ADDR, 1'b1, 1'b0, 8'h7F);
      acc(WDR_MODE_ADDR, 1'b0, 1'b0, 8'h00);
      chk(rdata_o, 8'h20);
      snap();
      repeat (3) begin
         repeat (400) @(posedge clk_i);
         acc(WDR_KEY_ADDR, 1'b1, 1'b0, WDR_RESTART_KEY);
      end
      dlt(0, 0, 0);
      repeat (500) @(posedge clk_i);
      dlt(0, 0, 0);
      repeat (30) @(posedge clk_i);
      dlt(0, 1, 0);
      snap();
      bad(8'h00, 1'b0);
      dlt(0, 1, 0);
      snap();
      bad(WDR_RESTART_KEY, 1'b1);
      dlt(0, 1, 0);
      power_save_i = 1;
      snap();
      bad(8'h00, 1'b0);
      dlt(0, 0, 1);
      power_save_i = 0;
      $display("test_nmi_mode done");
   endtask
   task automatic test_ps_reset();
      do_reset();
      power_save_i = 1;
      snap();
      bad(8'h11, 1'b0);
      dlt(1, 0, 0);
      power_save_i = 0;
      $display("test_ps_reset done");
   endtask
   task automatic test_reset_mode();
      do_reset();
      acc(WDR_MODE_ADDR, 1'b1, 1'b0, 8'h60);
      snap();
      repeat (500) @(posedge clk_i);
      dlt(0, 0, 0);
      repeat (30) @(posedge clk_i);
      dlt(1, 0, 0);
      $display("test_reset_mode done");
   endtask
   task automatic test_disable();
      do_reset();
      acc(WDR_MODE_ADDR, 1'b1, 1'b0, 8'h1F);
      acc(WDR_MODE_ADDR, 1'b0, 1'b0, 8'h00);
      chk(rdata_o, 8'h1F);
      snap();
      repeat (600) @(posedge clk_i);
      bad(8'h00, 1'b0);
      dlt(0, 0, 0);
      $display("test_disable done");
   endtask
   task automatic conclude();
      $display("checked=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      do_reset();
      test_read();
      test_bad_key();
      test_nmi_mode();
      test_ps_reset();
      test_reset_mode();
      test_disable();
      conclude();
   end
endmodule // wdr_watchdog_tb
